// ==== hdl/stmc_consts.svh ====
// Register offsets, field positions, reset values and counts of the static memory controller
`ifndef STMC_CONSTS_SVH
`define STMC_CONSTS_SVH
`define STMC_OFF_CS0 8'h00
`define STMC_OFF_CS1 8'h04
`define STMC_OFF_CS2 8'h08
`define STMC_OFF_CS3 8'h0c
`define STMC_OFF_RSV0 8'h10
`define STMC_OFF_MC 8'h24
`define STMC_RST_CS0 32'h0000203d
`define STMC_RST_CS1 32'h10000000
`define STMC_RST_CS2 32'h20000000
`define STMC_RST_CS3 32'h30000000
`define STMC_RST_MC 32'h00000000
`define STMC_MASK_CS 32'hfff03fff
`define STMC_MASK_CS3 32'hfff13fff
`define STMC_MASK_MC 32'h00000010
`define STMC_DBW_LSB 0
`define STMC_NWS_LSB 2
`define STMC_WSE_BIT 5
`define STMC_MWS_BIT 6
`define STMC_REGION_SIZE_LSB 7
`define STMC_TDF_LSB 9
`define STMC_BAT_BIT 12
`define STMC_SELECT_LINE_ENABLE_BIT 13
`define STMC_LCD_BIT 16
`define STMC_BA_LSB 20
`define STMC_DRP_BIT 4
`define STMC_DBW_32 2'b10
`define STMC_PG_1M 2'b00
`define STMC_PG_4M 2'b01
`define STMC_PG_16M 2'b10
`define STMC_WS_MULT 7'd8
`define STMC_SETUP_CLKS 8'd2
`define STMC_HOLD_MAX 8'd8
`endif

// ==== hdl/stmc_pkg.sv ====
// Types shared by the static memory controller
package stmc_pkg;
    typedef enum logic [1:0] {STMC_SZ_BYTE, STMC_SZ_HALF, STMC_SZ_WORD} stmc_size_t;
    typedef enum logic [2:0] {ST_IDLE, ST_WAITF, ST_SETUP, ST_ACC, ST_WHOLD} stmc_state_t;
    typedef struct packed {
        logic [31:0] addr;
        logic [31:0] wdata;
        logic write;
        stmc_size_t size;
    } stmc_req_t;
    typedef struct packed {
        logic valid;
        logic [31:0] rdata;
    } stmc_resp_t;
    typedef struct packed {
        logic [3:0] chip_select_line_n;
        logic [3:0] byte_strobe_n;
        logic common_write_strobe_n;
        logic output_enable_strobe_n;
        logic data_oe_n;
        logic [21:0] addr;
        logic [31:0] dout;
    } stmc_pins_t;
endpackage

// ==== hdl/stmc_top.sv ====
// Static memory controller: configuration registers, decoder and strobe sequencer
// What this block does
// - Reset loads defaults, select 0 16-bit
// - Width code 01 16-bit, 10 32-bit
// - Wait count plus one, only when enabled
// - Multiply gives (count+1)*8+1 waits
// - Region size picks compared base bits
// - Float cycles 0..7 only after reads
// - Lane mode: byte write or select
// - Select line driven only when enabled
// - Display mode bit only in select 3
// - Read timing bit: standard or early
// - Byte strobes follow write or select timing
// - One wait: full cycle; zero: half
// - Select change: address early, strobes late
// - Early-read wait only for same memory
// - Standard read: enable falls mid-cycle
// - Hold address and data until strobe sensed
// - Byte strobes follow size and address
// - No float wait for same memory
// - Select change wait only without other wait
// - Early read: write then read adds wait
//
// The address-and-strobe port was chosen for this implementation.
`timescale 1ns/100ps
`include "stmc_consts.svh"

module stmc_top (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic nrst,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // Internal access port
    input wire stmc_pkg::stmc_req_t req,
    input wire logic req_valid,
    output logic req_ready,
    output stmc_pkg::stmc_resp_t resp,
    // External memory pins
    output stmc_pkg::stmc_pins_t pins,
    input wire logic [31:0] ext_data_in,
    input wire logic wr_strobe_sense_n
);
    import stmc_pkg::*;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!nrst);

    logic [31:0] csr_q [4];
    logic [31:0] mc_q;
    logic [31:0] reg_rdata_q;
    logic [31:0] cfg;
    logic [3:0] hit;
    logic [1:0] sel_cs;
    logic sel_hit;
    logic [6:0] ws;
    logic [3:0] be;
    logic take, same, early, last_h, hold_exit;
    logic cs_act, wlow, oelow;
    stmc_state_t st_q;
    logic [7:0] h_q, tgt_q, wend_q;
    logic [6:0] ws_q;
    logic [1:0] acc_cs_q;
    logic [3:0] acc_be_q;
    logic acc_wr_q, bat_q, lcd_q;
    logic [2:0] tdf_q;
    logic [3:0] float_q;
    logic [1:0] last_cs_q;
    logic last_valid_q, last_wr_q;
    logic sense_s1_q, sense_s2_q, seen_low_q;
    logic [31:0] din_s1v_q, din_s2_q;
    logic [2:0] cap_q;
    stmc_pins_t pins_q;
    stmc_resp_t resp_q;

    // Register writes; masks keep reserved bits at zero
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            csr_q[0] <= `STMC_RST_CS0;
            csr_q[1] <= `STMC_RST_CS1;
            csr_q[2] <= `STMC_RST_CS2;
            csr_q[3] <= `STMC_RST_CS3;
            mc_q <= `STMC_RST_MC;
        end else if (reg_wr) begin
            case (reg_addr)
                `STMC_OFF_CS0: csr_q[0] <= reg_wdata & `STMC_MASK_CS;
                `STMC_OFF_CS1: csr_q[1] <= reg_wdata & `STMC_MASK_CS;
                `STMC_OFF_CS2: csr_q[2] <= reg_wdata & `STMC_MASK_CS;
                `STMC_OFF_CS3: csr_q[3] <= reg_wdata & `STMC_MASK_CS3;
                `STMC_OFF_MC: mc_q <= reg_wdata & `STMC_MASK_MC;
                default: ;
            endcase
        end
    end

    // Read data, valid only in the cycle after the strobe
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            reg_rdata_q <= 32'h0;
        end else if (reg_rd) begin
            case (reg_addr)
                `STMC_OFF_CS0: reg_rdata_q <= csr_q[0];
                `STMC_OFF_CS1: reg_rdata_q <= csr_q[1];
                `STMC_OFF_CS2: reg_rdata_q <= csr_q[2];
                `STMC_OFF_CS3: reg_rdata_q <= csr_q[3];
                `STMC_OFF_MC: reg_rdata_q <= mc_q;
                default: reg_rdata_q <= 32'h0;
            endcase
        end else begin
            reg_rdata_q <= 32'h0;
        end
    end
    assign reg_rdata = reg_rdata_q;

    // Region decode; bits below the region size are ignored
    always_comb begin
        hit = 4'h0;
        for (int i = 0; i < 4; i++) begin
            case (csr_q[i][`STMC_REGION_SIZE_LSB +: 2])
                `STMC_PG_1M: hit[i] = req.addr[31:20] == csr_q[i][31:20];
                `STMC_PG_4M: hit[i] = req.addr[31:22] == csr_q[i][31:22];
                `STMC_PG_16M: hit[i] = req.addr[31:24] == csr_q[i][31:24];
                default: hit[i] = 1'b0;
            endcase
            hit[i] = hit[i] & csr_q[i][`STMC_SELECT_LINE_ENABLE_BIT];
        end
    end

    // Lowest select wins; overlap also arises where a larger region covers another base
    always_comb begin
        sel_hit = |hit;
        sel_cs = 2'd0;
        for (int i = 3; i >= 0; i--) begin
            if (hit[i]) begin
                sel_cs = 2'(i);
            end
        end
    end
    assign cfg = csr_q[sel_cs];

    // Standard wait states of the selected region
    always_comb begin
        if (!cfg[`STMC_WSE_BIT]) begin
            ws = 7'd0;
        end else if (cfg[`STMC_MWS_BIT]) begin
            ws = ({4'd0, cfg[`STMC_NWS_LSB +: 3]} + 7'd1) * `STMC_WS_MULT + 7'd1;
        end else begin
            ws = {4'd0, cfg[`STMC_NWS_LSB +: 3]} + 7'd1;
        end
    end

    // Byte lanes; a 16-bit bus folds upper lanes onto lanes 0 and 1
    always_comb begin
        case (req.size)
            STMC_SZ_WORD: be = 4'hf;
            STMC_SZ_HALF: be = req.addr[1] ? 4'hc : 4'h3;
            default: be = 4'b0001 << req.addr[1:0];
        endcase
        if (cfg[`STMC_DBW_LSB +: 2] != `STMC_DBW_32) begin
            be = {2'b00, be[3:2] | be[1:0]};
        end
    end

    assign req_ready = (st_q == ST_IDLE) && (cap_q == 3'b000);
    assign take = req_valid && req_ready;
    assign same = last_valid_q && (last_cs_q == sel_cs);
    assign early = mc_q[`STMC_DRP_BIT];
    assign last_h = h_q == tgt_q - 8'd1;
    assign hold_exit = (seen_low_q && sense_s2_q) || (h_q == `STMC_HOLD_MAX);

    // Access sequencer; one access clock pair forms one bus cycle
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            st_q <= ST_IDLE;
            h_q <= 8'd0;
            tgt_q <= 8'd2;
            wend_q <= 8'd1;
            ws_q <= 7'd0;
            acc_cs_q <= 2'd0;
            acc_be_q <= 4'h0;
            acc_wr_q <= 1'b0;
            bat_q <= 1'b0;
            lcd_q <= 1'b0;
            tdf_q <= 3'd0;
        end else begin
            case (st_q)
                ST_IDLE: begin
                    h_q <= 8'd0;
                    if (take && sel_hit) begin
                        ws_q <= ws;
                        tgt_q <= 8'd2 + {ws, 1'b0};
                        wend_q <= (ws == 7'd0) ? 8'd1 : {ws, 1'b0};
                        acc_cs_q <= sel_cs;
                        acc_be_q <= be;
                        acc_wr_q <= req.write;
                        bat_q <= cfg[`STMC_BAT_BIT];
                        lcd_q <= cfg[`STMC_LCD_BIT];
                        tdf_q <= cfg[`STMC_TDF_LSB +: 3];
                        if (last_valid_q && !same && float_q != 4'd0) begin
                            st_q <= ST_WAITF;
                        end else if (last_valid_q && !same) begin
                            st_q <= ST_SETUP;
                        end else if (early && last_wr_q && same && !req.write) begin
                            st_q <= ST_SETUP;
                        end else begin
                            st_q <= ST_ACC;
                        end
                    end
                end
                ST_WAITF: begin
                    // Float time already separates the accesses
                    if (float_q == 4'd0) begin
                        st_q <= ST_ACC;
                    end
                end
                ST_SETUP: begin
                    if (h_q == `STMC_SETUP_CLKS - 8'd1) begin
                        h_q <= 8'd0;
                        st_q <= ST_ACC;
                    end else begin
                        h_q <= h_q + 8'd1;
                    end
                end
                ST_ACC: begin
                    if (last_h) begin
                        h_q <= 8'd0;
                        st_q <= acc_wr_q ? ST_WHOLD : ST_IDLE;
                    end else begin
                        h_q <= h_q + 8'd1;
                    end
                end
                ST_WHOLD: begin
                    // Timeout keeps a dead sense pin from hanging the bus
                    if (hold_exit) begin
                        h_q <= 8'd0;
                        st_q <= ST_IDLE;
                    end else begin
                        h_q <= h_q + 8'd1;
                    end
                end
                default: st_q <= ST_IDLE;
            endcase
        end
    end

    // Address and write data go out when the request is taken
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            pins_q.addr <= 22'h0;
            pins_q.dout <= 32'h0;
        end else if (take && sel_hit) begin
            pins_q.addr <= req.addr[21:0];
            pins_q.dout <= req.wdata;
        end
    end

    // Float counter in clocks, running through internal idle time too
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            float_q <= 4'd0;
        end else if (st_q == ST_ACC && last_h && !acc_wr_q) begin
            float_q <= {tdf_q, 1'b0};
        end else if (float_q != 4'd0) begin
            float_q <= float_q - 4'd1;
        end
    end

    // Memory and direction of the previous external access
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            last_valid_q <= 1'b0;
            last_cs_q <= 2'd0;
            last_wr_q <= 1'b0;
        end else if (st_q == ST_ACC && last_h) begin
            last_valid_q <= 1'b1;
            last_cs_q <= acc_cs_q;
            last_wr_q <= acc_wr_q;
        end
    end

    // Strobe shapes within an access
    always_comb begin
        cs_act = (st_q == ST_ACC) && (!lcd_q || (h_q != 8'd0 && !last_h));
        wlow = (st_q == ST_ACC) && acc_wr_q && (h_q != 8'd0) && (h_q <= wend_q);
        oelow = (st_q == ST_ACC) && !acc_wr_q && (early || h_q != 8'd0);
    end

    // Pin strobes registered so the pins never glitch
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            pins_q.chip_select_line_n <= 4'hf;
            pins_q.byte_strobe_n <= 4'hf;
            pins_q.common_write_strobe_n <= 1'b1;
            pins_q.output_enable_strobe_n <= 1'b1;
            pins_q.data_oe_n <= 1'b1;
        end else begin
            pins_q.chip_select_line_n <= ~({4{cs_act}} & (4'b0001 << acc_cs_q));
            if (bat_q) begin
                pins_q.byte_strobe_n <= ~(acc_be_q & {4{cs_act}});
            end else begin
                pins_q.byte_strobe_n <= ~(acc_be_q & {4{wlow}});
            end
            pins_q.common_write_strobe_n <= ~wlow;
            pins_q.output_enable_strobe_n <= ~oelow;
            pins_q.data_oe_n <= ~((st_q == ST_ACC || st_q == ST_WHOLD) && acc_wr_q);
        end
    end
    assign pins = pins_q;

    // Pin synchronisers
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            din_s1v_q <= 32'h0;
            din_s2_q <= 32'h0;
            sense_s1_q <= 1'b1;
            sense_s2_q <= 1'b1;
        end else begin
            din_s1v_q <= ext_data_in;
            din_s2_q <= din_s1v_q;
            sense_s1_q <= wr_strobe_sense_n;
            sense_s2_q <= sense_s1_q;
        end
    end
    // Strobe must be seen low before its rise ends the hold
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            seen_low_q <= 1'b0;
        end else if (take) begin
            seen_low_q <= 1'b0;
        end else if ((st_q == ST_ACC || st_q == ST_WHOLD) && !sense_s2_q) begin
            seen_low_q <= 1'b1;
        end
    end

    // Read capture lags the synchroniser; responses one cycle long
    // Third stage: the pin sample must come from the clock with the enable pin low
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            cap_q <= 3'b000;
            resp_q <= '0;
        end else begin
            cap_q <= {cap_q[1:0], st_q == ST_ACC && last_h && !acc_wr_q};
            resp_q.valid <= cap_q[2] || (st_q == ST_WHOLD && hold_exit) || (take && !sel_hit);
            resp_q.rdata <= cap_q[2] ? din_s2_q : 32'h0;
        end
    end
    assign resp = resp_q;

    // Helper: length of the write strobe in clocks
    logic [7:0] wl_cnt_q;
    logic wlow_q;
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            wl_cnt_q <= 8'd0;
            wlow_q <= 1'b0;
        end else begin
            wlow_q <= wlow;
            wl_cnt_q <= wlow ? wl_cnt_q + 8'd1 : 8'd0;
        end
    end

    rst_dflt_a: assert property ($rose(nrst) |-> csr_q[0] == `STMC_RST_CS0 && mc_q == 32'h0)
        else $error("reset defaults wrong");
    rsv_read_a: assert property (reg_rd && reg_addr == `STMC_OFF_RSV0 |=> reg_rdata == 32'h0)
        else $error("reserved offset read nonzero");
    lcd_only3_a: assert property (!csr_q[0][16] && !csr_q[1][16] && !csr_q[2][16])
        else $error("display bit set outside select 3");
    no_wait_a: assert property (take && sel_hit && !cfg[`STMC_WSE_BIT] |=> ws_q == 7'd0)
        else $error("waits added while disabled");
    mult_wait_a: assert property (take && sel_hit && cfg[`STMC_WSE_BIT] && cfg[`STMC_MWS_BIT]
        && cfg[4:2] == 3'd0 |=> ws_q == 7'd9 && tgt_q == 8'd20)
        else $error("multiplied waits wrong");
    wr_full_a: assert property (wlow_q && !wlow && ws_q == 7'd1 |-> wl_cnt_q == 8'd2)
        else $error("one-wait strobe not a full cycle");
    wr_half_a: assert property (wlow_q && !wlow && ws_q == 7'd0 |-> wl_cnt_q == 8'd1)
        else $error("zero-wait strobe not a half cycle");
    oe_time_a: assert property (st_q == ST_ACC && h_q == 8'd0 && !acc_wr_q
        |=> pins.output_enable_strobe_n == !$past(early))
        else $error("read enable timing wrong");
    float_gap_a: assert property ($rose(st_q == ST_ACC) |-> float_q == 4'd0
        || acc_cs_q == last_cs_q)
        else $error("access began inside float time");
    hold_a: assert property (st_q == ST_WHOLD |=> !pins.data_oe_n)
        else $error("data released before strobe sensed");
    byte2_a: assert property (take && sel_hit && req.size == STMC_SZ_BYTE && req.addr[1:0] == 2'd2
        && cfg[1:0] == `STMC_DBW_32 |=> acc_be_q == 4'h4)
        else $error("byte lane wrong");
    en_sel_a: assert property (cs_act |-> csr_q[acc_cs_q][`STMC_SELECT_LINE_ENABLE_BIT]
        || $past(st_q) == ST_ACC)
        else $error("disabled select driven");

    er_wait_c: cover property (st_q == ST_SETUP && acc_cs_q == last_cs_q);
    float_c: cover property (st_q == ST_WAITF ##1 st_q == ST_ACC);
    lcd_c: cover property (st_q == ST_ACC && lcd_q && acc_wr_q);
endmodule

// ==== verif/stmc_mem_model.sv ====
// Behavioural external static memory sitting on the controller pins
`timescale 1ns/100ps
module stmc_mem_model (
    // Clock
    input wire logic clk_sys,
    // Controller pins and board speed
    input wire stmc_pkg::stmc_pins_t pins,
    input wire logic slow,
    // Memory side
    output logic [31:0] ext_data_in,
    output logic wr_strobe_sense_n
);
    import stmc_pkg::*;
    logic [31:0] mem [0:255];
    logic [31:0] last_q = 32'h0;
    logic drive_q = 1'b0;
    logic [1:0] sense_q = 2'h3;
    logic [7:0] idx;
    logic sel;
    logic rd_on;

    // Word index from the lowest active select
    always_comb begin
        sel = ~&pins.chip_select_line_n;
        idx = {2'h0, pins.addr[7:2]};
        for (int i = 3; i >= 0; i--) begin
            if (!pins.chip_select_line_n[i]) idx = {2'(i), pins.addr[7:2]};
        end
    end
    assign rd_on = sel && !pins.output_enable_strobe_n;

    // Store only lanes whose strobe is low while the controller drives data
    always @(posedge clk_sys) begin
        for (int b = 0; b < 4; b++) begin
            if (sel && !pins.data_oe_n && !pins.byte_strobe_n[b]) begin
                mem[idx][8*b +: 8] <= pins.dout[8*b +: 8];
            end
        end
        drive_q <= rd_on;
        if (rd_on) last_q <= mem[idx];
        sense_q <= {sense_q[0], pins.common_write_strobe_n};
    end

    // Released bus holds data one clock, then shows inverted data, so a later sample cannot pass
    assign ext_data_in = rd_on ? mem[idx] : (drive_q ? last_q : ~last_q);
    // Heavily loaded strobe reaches the sense pin two clocks late
    assign wr_strobe_sense_n = slow ? sense_q[1] : pins.common_write_strobe_n;
endmodule

// ==== verif/test_static_memory_controller_config.sv ====
// Self-checking bench for registers, data paths and strobe timing
`timescale 1ns/100ps
module test_static_memory_controller_config;
    import stmc_pkg::*;
    localparam logic [31:0] addr_cs0 = 32'h0;
    localparam logic [31:0] addr_cs1 = 32'h00100000;
    logic clk_sys, nrst, reg_wr, reg_rd, req_valid, req_ready, slow, wr_strobe_sense_n;
    logic [7:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata, ext_data_in, rd, a, d, m;
    logic [31:0] ref_mem [0:255];
    logic [7:0] offs [11] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h24, 8'h10, 8'h20,
        8'h08, 8'h0c, 8'h24, 8'h10};
    logic [31:0] expv [11] = '{32'h0000203d, 32'h10000000, 32'h20000000, 32'h30000000,
        32'h0, 32'h0, 32'h0, 32'hffe03fff, 32'hfff13fff, 32'h00000010, 32'h0};
    stmc_req_t req;
    stmc_resp_t resp;
    stmc_pins_t pins;
    stmc_size_t s;
    integer seed = 22;
    int error_cnt, check_count, lat, n_wr, n_oe, n_doe, w, p, b0, bs, bd, bf, br;
    int n_cs [4];

    stmc_top dut (
        .clk_sys(clk_sys), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .req(req),
        .req_valid(req_valid), .req_ready(req_ready), .resp(resp), .pins(pins),
        .ext_data_in(ext_data_in), .wr_strobe_sense_n(wr_strobe_sense_n)
    );
    stmc_mem_model mem0 (
        .clk_sys(clk_sys), .pins(pins), .slow(slow), .ext_data_in(ext_data_in),
        .wr_strobe_sense_n(wr_strobe_sense_n)
    );

    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    // Running totals of active pin clocks, read as differences
    always @(posedge clk_sys) begin
        n_wr += !pins.common_write_strobe_n;
        n_oe += !pins.output_enable_strobe_n;
        n_doe += !pins.data_oe_n;
        for (int i = 0; i < 4; i++) n_cs[i] += !pins.chip_select_line_n[i];
    end

    task automatic final_report();
        $display("checks %0d errors %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Byte lanes that an access of this size and offset must touch
    function automatic logic [31:0] lane_mask(input stmc_size_t sz, input logic [1:0] off);
        logic [3:0] l;
        l = sz == STMC_SZ_HALF ? (off[1] ? 4'hc : 4'h3) : 4'h1 << off;
        if (sz == STMC_SZ_WORD) l = 4'hf;
        return {{8{l[3]}}, {8{l[2]}}, {8{l[1]}}, {8{l[0]}}};
    endfunction

    // One register cycle; read data stands in the following cycle
    task automatic reg_acc(input logic wr, input logic [7:0] ad, input logic [31:0] dd);
        @(posedge clk_sys);
        reg_addr <= ad;
        reg_wdata <= dd;
        reg_wr <= wr;
        reg_rd <= !wr;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        #1;
        rd = reg_rdata;
    endtask

    // Request held until taken; lat counts clocks from take to response
    task automatic acc(input logic [31:0] aa, dd, input logic wr, input stmc_size_t sz);
        @(posedge clk_sys);
        req <= '{aa, dd, wr, sz};
        req_valid <= 1'b1;
        lat = 0;
        do begin
            @(negedge clk_sys);
            lat++;
        end while (req_ready !== 1'b1 && lat < 300);
        @(posedge clk_sys);
        req_valid <= 1'b0;
        #1;
        lat = (lat < 300) ? 1 : 300;
        while (resp.valid !== 1'b1 && lat < 300) begin
            @(posedge clk_sys);
            #1;
            lat++;
        end
        rd = resp.rdata;
        if (lat >= 300) begin
            error_cnt++;
            $display("ERROR t=%0t got=%h exp=%h", $time, lat, 32'h1);
            final_report();
        end
    endtask

    task automatic pair(input logic [31:0] a1, a2, input logic w1, w2);
        acc(a1, 32'h0, w1, STMC_SZ_WORD);
        acc(a2, 32'h0, w2, STMC_SZ_WORD);
    endtask

    initial begin
        nrst = 1'b0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 8'h0;
        reg_wdata = 32'h0;
        req_valid = 1'b0;
        req = '0;
        slow = 1'b0;
        repeat (16) @(posedge clk_sys);
        nrst <= 1'b1;
        // Reset setup of select 0: 16-bit bus, eight enabled waits
        w = n_wr;
        acc(addr_cs0, 32'h0, 1'b1, STMC_SZ_WORD);
        check(n_wr - w, 16);
        // Defaults first, then masked write-backs including two unmapped offsets
        for (int i = 0; i < 11; i++) begin
            if (i > 4) reg_acc(1'b1, offs[i], i == 7 ? 32'hffefffff : 32'hffffffff);
            reg_acc(1'b0, offs[i], 32'h0);
            check(rd, expv[i]);
        end
        reg_acc(1'b1, 8'h00, 32'h00002002);
        reg_acc(1'b1, 8'h04, 32'h00103002); // distinct bases
        reg_acc(1'b1, 8'h08, 32'h00200002);
        reg_acc(1'b1, 8'h0c, 32'h30000000);
        reg_acc(1'b1, 8'h24, 32'h0);
        $display("registers done");
        // Byte write mode on select 0, byte select mode on select 1
        for (int i = 0; i < 128; i++) begin
            d = $random(seed);
            ref_mem[i] = d;
            acc({11'h0, i[6], 12'h0, i[5:0], 2'b00}, d, 1'b1, STMC_SZ_WORD);
        end
        for (int k = 0; k < 60; k++) begin
            a = $random(seed) & 32'h001000fc;
            s = stmc_size_t'(2'($unsigned($random(seed)) % 3));
            d = $random(seed);
            if (s == STMC_SZ_HALF) a[1] = d[0];
            if (s == STMC_SZ_BYTE) a[1:0] = d[1:0];
            m = lane_mask(s, a[1:0]);
            if (d[31]) begin
                ref_mem[{a[20], a[7:2]}] = (ref_mem[{a[20], a[7:2]}] & ~m) | (d & m);
                acc(a, d, 1'b1, s);
            end else begin
                acc(a, d, 1'b0, s);
                check(rd & m, ref_mem[{a[20], a[7:2]}] & m);
            end
        end
        $display("data done");
        // Wait counts, a disabled count and a multiplied count
        for (int n = 0; n < 10; n++) begin
            reg_acc(1'b1, 8'h00, n < 8 ? 32'h2022 | 32'(n << 2) : n == 8 ? 32'h201e : 32'h2062);
            w = n_wr;
            acc(addr_cs0, 32'h0, 1'b1, STMC_SZ_WORD);
            check(n_wr - w, n < 8 ? 2 * n + 2 : n == 8 ? 1 : 18);
        end
        reg_acc(1'b1, 8'h00, 32'h00002002);
        reg_acc(1'b1, 8'h04, 32'h00103082);
        w = n_cs[1];
        acc(32'h00300000, 32'h0, 1'b1, STMC_SZ_WORD);
        check(n_cs[1] > w, 1);
        reg_acc(1'b1, 8'h04, 32'h00103182);
        acc(addr_cs1, 32'h0, 1'b1, STMC_SZ_WORD);
        check(lat, 1);
        w = n_cs[2];
        acc(32'h00200000, 32'h0, 1'b0, STMC_SZ_WORD);
        check(n_cs[2] - w, 0);
        reg_acc(1'b1, 8'h04, 32'h00103002);
        // Display mode on select 3: two waits, select shortened at both ends
        reg_acc(1'b1, 8'h0c, 32'h30012026);
        w = n_cs[3];
        acc(32'h30000000, 32'h0, 1'b1, STMC_SZ_WORD);
        check(n_cs[3] - w, 4);
        // Gaps between consecutive accesses
        pair(addr_cs0, addr_cs0, 1'b1, 1'b1);
        b0 = lat;
        pair(addr_cs1, addr_cs0, 1'b1, 1'b1);
        check(lat, b0 + 2);
        w = n_oe;
        pair(addr_cs0, addr_cs0, 1'b1, 1'b0);
        bs = lat;
        check(n_oe - w, 1);
        pair(addr_cs1, addr_cs0, 1'b1, 1'b0);
        bd = lat;
        pair(addr_cs1, addr_cs0, 1'b0, 1'b1);
        bf = lat;
        pair(addr_cs1, addr_cs1, 1'b0, 1'b0);
        br = lat;
        reg_acc(1'b1, 8'h24, 32'h00000010);
        w = n_oe;
        pair(addr_cs0, addr_cs0, 1'b1, 1'b0);
        check(lat, bs + 2);
        check(n_oe - w, 2);
        pair(addr_cs1, addr_cs0, 1'b1, 1'b0);
        check(lat, bd);
        reg_acc(1'b1, 8'h24, 32'h0);
        reg_acc(1'b1, 8'h04, 32'h00103e02);
        pair(addr_cs1, addr_cs0, 1'b1, 1'b1);
        check(lat, b0 + 2);
        pair(addr_cs1, addr_cs0, 1'b0, 1'b1);
        check(lat > bf, 1);
        pair(addr_cs1, addr_cs1, 1'b0, 1'b0);
        check(lat, br);
        $display("timing done");
        // Data stays driven until the strobe edge is sensed
        acc(addr_cs0, 32'h0, 1'b1, STMC_SZ_WORD);
        w = n_doe;
        acc(addr_cs0, 32'h0, 1'b1, STMC_SZ_WORD);
        p = n_doe - w;
        slow <= 1'b1;
        w = n_doe;
        acc(addr_cs0, 32'h0, 1'b1, STMC_SZ_WORD);
        check(n_doe - w, p + 2);
        $display("hold done");
        final_report();
    end
endmodule
